// ==== hardened_i2c_core_pair_test.sv ====
/* Bench for the core pair: register rows, master writes on both cores and a slave
   address match at an 80 ns link clock. Assumes the checker binds itself. */
`timescale 1ns/1ns
`default_nettype none
module hardened_i2c_core_pair_test;
  import hi2c_pkg::*;
  typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} hi2c_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, m_scl = 1'b0, m_sda = 1'b0, ack_en = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er;
  wire logic [1:0] scl_i, sda_i;
  logic [1:0] scl_oe, sda_oe, irq, wk, sb;
  logic wk_seen = 1'b0;
  logic [7:0] rx;
  int n_fail = 0, checks = 0, cyc = 0;
  hi2c_row_s rows [15] = '{'{0, 12'h000, 0, 0, 0}, '{1, 12'h000, 8'h03, 0, 0},
    '{0, 12'h000, 0, 8'h03, 0}, '{1, 12'h028, 8'h0F, 0, 0}, '{0, 12'h028, 0, 8'h0F, 0},
    '{1, 12'h010, 8'hA5, 0, 0}, '{0, 12'h004, 0, 0, 0}, '{0, 12'h02C, 0, 0, 1},
    '{1, 12'h080, 8'h03, 0, 1}, '{0, 12'h002, 0, 0, 1}, '{1, 12'h040, 8'h03, 0, 0},
    '{1, 12'h068, 8'h01, 0, 0}, '{1, 12'h050, 8'h5A, 0, 0}, '{0, 12'h058, 0, 0, 0},
    '{0, 12'h040, 0, 8'h03, 0}};
  hi2c_embedded_function_wrapper hi2c_embedded_function_wrapper_i (.*, .scl_o(), .sda_o(),
    .wake_req(wk), .stdby_req(sb));
  hi2c_peer hi2c_peer_i (.scl_oe(scl_oe[0]), .sda_oe(sda_oe[0]), .m_scl(m_scl), .m_sda(m_sda),
    .ack_en(ack_en), .scl(scl_i[0]), .sda(sda_i[0]), .rx(rx));
  // The second bus has pull-ups only, so nobody acknowledges there.
  assign scl_i[1] = !scl_oe[1];
  assign sda_i[1] = !sda_oe[1];
  always #2 pclk = !pclk;
  // The wake request is a one-cycle pulse, so keep a sticky copy of it.
  always @(posedge pclk) if (wk[0]) wk_seen <= 1'b1;
  // A hang ends the run as a failure.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request holds until pready is seen at a rising edge; two idle edges follow.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic step(logic c, logic d);
    m_scl <= c;
    m_sda <= d;
    repeat (5) @(posedge pclk);
  endtask
  task automatic mst(int i, logic nak);
    logic [11:0] b = 12'(i) << 6;
    apb(1, b | OFS_CMD, 32'h0000_000B);
    do apb(0, b | OFS_STAT, 0); while (rd[STAT_TIP] !== 1'b0);
    chk("rxnak", rd[STAT_RXNAK], nak);
    apb(1, b | OFS_IMASK, 0);
    chk("irq masked", irq[i], 0);
    apb(1, b | OFS_IMASK, 32'h0000_000F);
    chk("irq", irq[i], 1);
    apb(1, b | OFS_ISTAT, 32'h0000_000F);
    apb(0, b | OFS_ISTAT, 0);
    chk("istat cleared", rd, 0);
    chk("irq cleared", irq[i], 0);
  endtask
  // Bench master frame on bus 0: start, address byte, ack check, stop.
  task automatic slv(logic [7:0] v);
    step(0, 1);
    step(1, 1);
    for (int k = 7; k >= 0; k--) begin
      for (int p = 0; p < 4; p++) step(p == 0 || p == 3, !v[k]);
    end
    step(1, 0);
    step(0, 0);
    chk("slave ack", sda_i[0], 0);
    step(0, 0);
    step(1, 1);
    step(0, 1);
    step(0, 0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    chk("scl_oe in reset", scl_oe, 0);
    presetn <= 1'b1;
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].a, {24'h00_0000, rows[k].d});
      chk("slverr", er, rows[k].e);
      if (!rows[k].w) chk("rdata", rd, {24'h00_0000, rows[k].x});
    end
    $display("register rows done");
    mst(0, 0);
    chk("wire byte", rx, 8'hA5);
    $display("core 0 master done");
    mst(1, 1);
    $display("core 1 master done");
    apb(1, 12'h018, 32'h0000_0050);
    apb(1, 12'h000, 32'h0000_0011);
    chk("standby", sb[0], 1);
    ack_en <= 1'b0;
    slv(8'hA0);
    apb(0, 12'h024, 0);
    chk("adr and stop", rd[3:2], 2'b11);
    chk("wake", wk_seen, 1);
    apb(1, 12'h024, 32'h0000_000F);
    apb(1, 12'h000, 32'h0000_0019);
    slv(8'h00);
    apb(0, 12'h024, 0);
    chk("gc adr and stop", rd[3:2], 2'b11);
    apb(0, 12'h020, 0);
    chk("gc flag", rd[STAT_GC], 1);
    $display("slave match done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk("ctrl after reset", rd, 0);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== hi2c_embedded_function_wrapper.sv ====
/*
  Pair of two-wire serial cores with an APB register slave, per-core
  interrupt and wake/standby outputs.
  Assumes external pull-ups on both lines and a 250 MHz pclk.
*/
`timescale 1ns/1ns
`default_nettype none

module hi2c_embedded_function_wrapper
  import hi2c_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock lines, index 0 on fixed pads, index 1 on user pads.
  input wire logic [NCORE-1:0] scl_i,
  output logic [NCORE-1:0] scl_o,
  output logic [NCORE-1:0] scl_oe,
  // Data lines.
  input wire logic [NCORE-1:0] sda_i,
  output logic [NCORE-1:0] sda_o,
  output logic [NCORE-1:0] sda_oe,
  // Interrupts and power module requests.
  output logic [NCORE-1:0] irq,
  output logic [NCORE-1:0] wake_req,
  output logic [NCORE-1:0] stdby_req
);

  // ------------------------------------------------------------------
  // APB decode. One wait state lets the read data come from a flop.
  // ------------------------------------------------------------------
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic acc;
  logic hit;
  logic [7:0] core_rd [NCORE];

  assign acc = psel & penable & pready_reg;
  assign hit = (paddr[APB_AW-1:CORE_SEL_BIT+1] == '0) && (paddr[1:0] == 2'b00)
    && (paddr[5:0] <= OFS_IMASK);
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // Answer every access one cycle after its access phase opens.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable && !pready_reg) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !hit;
      prdata_reg <= (hit && !pwrite) ? {24'h00_0000, core_rd[paddr[CORE_SEL_BIT]]}
        : 32'h0000_0000;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Per-core logic; both copies are the same.
  // ------------------------------------------------------------------
  for (genvar c = 0; c < NCORE; c++) begin : g_core
    logic wr;
    logic [5:0] ofs;
    logic scl_s;
    logic sda_s;
    logic scl_p_reg;
    logic sda_p_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [7:0] ctrl_reg;
    logic [15:0] div_reg;
    logic [15:0] div_eff;
    logic [7:0] txd_reg;
    logic [7:0] rxd_reg;
    logic [9:0] sad_reg;
    logic [3:0] ist_reg;
    logic [3:0] imask_reg;
    logic [3:0] ev;
    logic busy_reg;
    logic rxnak_reg;
    logic arbl_reg;
    logic gch_reg;
    logic srw_reg;
    logic ten_hit_reg;
    logic irq_reg;
    logic wake_reg;
    logic stdby_reg;
    logic sda_oe_reg;
    logic mst_on;
    logic slv_on;
    hi2c_mst_e mst_reg;
    logic [1:0] ph_reg;
    logic [15:0] qcnt_reg;
    logic tick;
    logic [3:0] bcnt_reg;
    logic [7:0] sh_reg;
    logic scl_drv_reg;
    logic sda_drv_reg;
    logic own_reg;
    logic pend_sta_reg;
    logic pend_byte_reg;
    logic pend_rd_reg;
    logic pend_sto_reg;
    logic nak_out_reg;
    logic m_byte_ev;
    logic m_arb_ev;
    hi2c_slv_e sst_reg;
    hi2c_slv_e snxt_reg;
    logic [3:0] sbc_reg;
    logic [7:0] ssh_reg;
    logic s_sda_reg;
    logic s_byte_ev;
    logic s_adr_ev;
    logic m7;
    logic gc;
    logic t1;

    hi2c_sync #(.RST_VAL(1'b1)) u_scl (
      .pclk(pclk),
      .presetn(presetn),
      .d_in(scl_i[c]),
      .q(scl_s)
    );
    hi2c_sync #(.RST_VAL(1'b1)) u_sda (
      .pclk(pclk),
      .presetn(presetn),
      .d_in(sda_i[c]),
      .q(sda_s)
    );

    assign ofs = paddr[5:0];
    assign wr = acc & pwrite & hit & (paddr[CORE_SEL_BIT] == 1'(c));
    assign mst_on = ctrl_reg[CTRL_EN] & ctrl_reg[CTRL_MST];
    assign slv_on = ctrl_reg[CTRL_EN] & !ctrl_reg[CTRL_MST];
    // A divider set below the floor is raised to it.
    assign div_eff = (div_reg < QTR_MIN_W) ? QTR_MIN_W : div_reg;
    assign tick = (qcnt_reg == 16'h0000);
    assign scl_rise = scl_s & !scl_p_reg;
    assign scl_fall = !scl_s & scl_p_reg;
    assign start_det = scl_s & scl_p_reg & sda_p_reg & !sda_s;
    assign stop_det = scl_s & scl_p_reg & !sda_p_reg & sda_s;
    assign ev = {stop_det & ctrl_reg[CTRL_EN], s_adr_ev, m_arb_ev, m_byte_ev | s_byte_ev};

    // Address compare for the first byte after a start.
    assign m7 = !ctrl_reg[CTRL_TEN] && (ssh_reg[7:1] == sad_reg[6:0]);
    assign gc = ctrl_reg[CTRL_GC] && (ssh_reg[7:1] == GC_ADDR) && !ssh_reg[0];
    assign t1 = ctrl_reg[CTRL_TEN] && (ssh_reg[7:3] == TEN_PREFIX)
      && (ssh_reg[2:1] == sad_reg[9:8]);

    // Register read mux.
    always_comb begin
      case (ofs)
        OFS_CTRL: core_rd[c] = ctrl_reg;
        OFS_DIVLO: core_rd[c] = div_reg[7:0];
        OFS_DIVHI: core_rd[c] = div_reg[15:8];
        OFS_TXD: core_rd[c] = txd_reg;
        OFS_RXD: core_rd[c] = rxd_reg;
        OFS_SADLO: core_rd[c] = sad_reg[7:0];
        OFS_SADHI: core_rd[c] = {6'h00, sad_reg[9:8]};
        OFS_STAT: core_rd[c] = {1'b0, gch_reg, srw_reg,
          (sst_reg == S_RX) || (sst_reg == S_TX), arbl_reg, rxnak_reg,
          (mst_reg != M_IDLE) | pend_sta_reg | pend_byte_reg | pend_sto_reg, busy_reg};
        OFS_ISTAT: core_rd[c] = {4'h0, ist_reg};
        OFS_IMASK: core_rd[c] = {4'h0, imask_reg};
        default: core_rd[c] = 8'h00;
      endcase
    end

    // Software-owned settings.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_reg <= CTRL_RST;
        div_reg <= QTR_MIN_W;
        txd_reg <= BYTE_RST;
        sad_reg <= SAD_RST;
        imask_reg <= IRQ_RST;
      end else if (wr) begin
        if (ofs == OFS_CTRL) ctrl_reg <= pwdata[7:0];
        if (ofs == OFS_DIVLO) div_reg[7:0] <= pwdata[7:0];
        if (ofs == OFS_DIVHI) div_reg[15:8] <= pwdata[7:0];
        if (ofs == OFS_TXD) txd_reg <= pwdata[7:0];
        if (ofs == OFS_SADLO) sad_reg[7:0] <= pwdata[7:0];
        if (ofs == OFS_SADHI) sad_reg[9:8] <= pwdata[1:0];
        if (ofs == OFS_IMASK) imask_reg <= pwdata[3:0];
      end
    end

    // Sticky events; a new event outweighs a write-one clear.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ist_reg <= IRQ_RST;
        irq_reg <= 1'b0;
      end else begin
        ist_reg <= (ist_reg & ~((wr && ofs == OFS_ISTAT) ? pwdata[3:0] : 4'h0)) | ev;
        irq_reg <= |(ist_reg & imask_reg);
      end
    end

    // Line history, bus busy and the power module requests.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scl_p_reg <= 1'b1;
        sda_p_reg <= 1'b1;
        busy_reg <= 1'b0;
        wake_reg <= 1'b0;
        stdby_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else begin
        scl_p_reg <= scl_s;
        sda_p_reg <= sda_s;
        if (start_det) busy_reg <= 1'b1;
        else if (stop_det) busy_reg <= 1'b0;
        wake_reg <= ctrl_reg[CTRL_WAKE] & s_adr_ev;
        stdby_reg <= ctrl_reg[CTRL_WAKE] & ctrl_reg[CTRL_EN] & !busy_reg
          & (sst_reg == S_IDLE) & (mst_reg == M_IDLE);
        // Data is pulled low only by the side now sending.
        sda_oe_reg <= sda_drv_reg | s_sda_reg;
      end
    end

    // Quarter-period timer; it halts while another party holds the clock low.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        qcnt_reg <= QTR_MIN_W;
      end else if (mst_reg == M_IDLE || tick) begin
        qcnt_reg <= div_eff - 16'h0001;
      end else if (scl_drv_reg || scl_s) begin
        qcnt_reg <= qcnt_reg - 16'h0001;
      end
    end

    // Master sequencer: start, byte with ack slot, stop.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mst_reg <= M_IDLE;
        ph_reg <= 2'b00;
        bcnt_reg <= 4'h0;
        sh_reg <= BYTE_RST;
        scl_drv_reg <= 1'b0;
        sda_drv_reg <= 1'b0;
        own_reg <= 1'b0;
        pend_sta_reg <= 1'b0;
        pend_byte_reg <= 1'b0;
        pend_rd_reg <= 1'b0;
        pend_sto_reg <= 1'b0;
        nak_out_reg <= 1'b0;
        rxnak_reg <= 1'b0;
        arbl_reg <= 1'b0;
        rxd_reg <= BYTE_RST;
        m_byte_ev <= 1'b0;
        m_arb_ev <= 1'b0;
      end else begin
        m_byte_ev <= 1'b0;
        m_arb_ev <= 1'b0;
        if (s_byte_ev) rxd_reg <= ssh_reg;
        if (!mst_on) begin
          // Leaving master mode frees the clock line at once.
          mst_reg <= M_IDLE;
          scl_drv_reg <= 1'b0;
          sda_drv_reg <= 1'b0;
          own_reg <= 1'b0;
          pend_sta_reg <= 1'b0;
          pend_byte_reg <= 1'b0;
          pend_sto_reg <= 1'b0;
        end else if (mst_reg == M_IDLE) begin
          if (wr && ofs == OFS_CMD) begin
            pend_sta_reg <= pwdata[CMD_STA];
            pend_sto_reg <= pwdata[CMD_STO];
            pend_byte_reg <= pwdata[CMD_RD] | pwdata[CMD_WR];
            pend_rd_reg <= pwdata[CMD_RD];
            nak_out_reg <= pwdata[CMD_NAK];
          end else if (pend_sta_reg && (!busy_reg || own_reg)) begin
            mst_reg <= M_START;
            arbl_reg <= 1'b0;
          end else if (pend_byte_reg && own_reg) begin
            mst_reg <= M_BYTE;
            bcnt_reg <= 4'h0;
            sh_reg <= pend_rd_reg ? 8'hFF : txd_reg;
          end else if (pend_sto_reg && own_reg) begin
            mst_reg <= M_STOP;
          end
          ph_reg <= 2'b00;
        end else if (tick) begin
          ph_reg <= ph_reg + 2'b01;
          case (mst_reg)
            M_START: begin
              case (ph_reg)
                2'b00: sda_drv_reg <= 1'b0;
                2'b01: scl_drv_reg <= 1'b0;
                2'b10: sda_drv_reg <= 1'b1;
                default: begin
                  scl_drv_reg <= 1'b1;
                  own_reg <= 1'b1;
                  pend_sta_reg <= 1'b0;
                  mst_reg <= M_IDLE;
                end
              endcase
            end
            M_BYTE: begin
              case (ph_reg)
                2'b00: sda_drv_reg <= (bcnt_reg == ACK_SLOT) ? (pend_rd_reg & !nak_out_reg)
                  : (!pend_rd_reg & !sh_reg[7]);
                2'b01: scl_drv_reg <= 1'b0;
                2'b10: sda_drv_reg <= sda_drv_reg;
                default: begin
                  scl_drv_reg <= 1'b1;
                  if (bcnt_reg != ACK_SLOT && !pend_rd_reg && sh_reg[7] && !sda_s) begin
                    // Another master won the bit; let go of both lines.
                    scl_drv_reg <= 1'b0;
                    sda_drv_reg <= 1'b0;
                    own_reg <= 1'b0;
                    arbl_reg <= 1'b1;
                    m_arb_ev <= 1'b1;
                    pend_byte_reg <= 1'b0;
                    pend_sto_reg <= 1'b0;
                    mst_reg <= M_IDLE;
                  end else if (bcnt_reg == ACK_SLOT) begin
                    rxnak_reg <= sda_s;
                    if (pend_rd_reg) rxd_reg <= sh_reg;
                    pend_byte_reg <= 1'b0;
                    m_byte_ev <= 1'b1;
                    mst_reg <= M_IDLE;
                  end else begin
                    sh_reg <= {sh_reg[6:0], sda_s};
                    bcnt_reg <= bcnt_reg + 4'h1;
                  end
                end
              endcase
            end
            M_STOP: begin
              case (ph_reg)
                2'b00: sda_drv_reg <= 1'b1;
                2'b01: scl_drv_reg <= 1'b0;
                2'b10: sda_drv_reg <= 1'b0;
                default: begin
                  own_reg <= 1'b0;
                  pend_sto_reg <= 1'b0;
                  mst_reg <= M_IDLE;
                end
              endcase
            end
            default: mst_reg <= M_IDLE;
          endcase
        end
      end
    end

    // Slave receiver and transmitter, stepped by clock line edges.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sst_reg <= S_IDLE;
        snxt_reg <= S_IDLE;
        sbc_reg <= 4'h0;
        ssh_reg <= BYTE_RST;
        s_sda_reg <= 1'b0;
        srw_reg <= 1'b0;
        gch_reg <= 1'b0;
        ten_hit_reg <= 1'b0;
        s_byte_ev <= 1'b0;
        s_adr_ev <= 1'b0;
      end else begin
        s_byte_ev <= 1'b0;
        s_adr_ev <= 1'b0;
        if (!slv_on || stop_det) begin
          sst_reg <= S_IDLE;
          s_sda_reg <= 1'b0;
          ten_hit_reg <= 1'b0;
        end else if (start_det) begin
          // The clock fall that closes a start carries no bit, so park in the
          // ack slot and let that fall only rearm the bit counter.
          sst_reg <= S_ADR1;
          sbc_reg <= ACK_SLOT;
          snxt_reg <= S_ADR1;
          s_sda_reg <= 1'b0;
        end else if (sst_reg != S_IDLE && sst_reg != S_HOLD) begin
          if (scl_rise && sbc_reg != ACK_SLOT && sst_reg != S_TX) begin
            ssh_reg <= {ssh_reg[6:0], sda_s};
          end else if (scl_rise && sst_reg == S_TX && sda_s) begin
            snxt_reg <= S_HOLD;
          end else if (scl_fall && sbc_reg < 4'h7) begin
            sbc_reg <= sbc_reg + 4'h1;
            if (sst_reg == S_TX) begin
              ssh_reg <= {ssh_reg[6:0], 1'b1};
              s_sda_reg <= !ssh_reg[6];
            end
          end else if (scl_fall && sbc_reg == 4'h7) begin
            sbc_reg <= ACK_SLOT;
            s_sda_reg <= 1'b1;
            snxt_reg <= sst_reg;
            case (sst_reg)
              S_ADR1: begin
                if (m7 || gc || (t1 && ssh_reg[0] && ten_hit_reg)) begin
                  srw_reg <= ssh_reg[0];
                  gch_reg <= gc;
                  s_adr_ev <= 1'b1;
                  snxt_reg <= ssh_reg[0] ? S_TX : S_RX;
                end else if (t1 && !ssh_reg[0]) begin
                  snxt_reg <= S_ADR2;
                end else begin
                  s_sda_reg <= 1'b0;
                  snxt_reg <= S_HOLD;
                end
              end
              S_ADR2: begin
                if (ssh_reg == sad_reg[7:0]) begin
                  ten_hit_reg <= 1'b1;
                  srw_reg <= 1'b0;
                  gch_reg <= 1'b0;
                  s_adr_ev <= 1'b1;
                  snxt_reg <= S_RX;
                end else begin
                  s_sda_reg <= 1'b0;
                  snxt_reg <= S_HOLD;
                end
              end
              S_RX: s_byte_ev <= 1'b1;
              default: s_sda_reg <= 1'b0;
            endcase
          end else if (scl_fall) begin
            sbc_reg <= 4'h0;
            sst_reg <= snxt_reg;
            if (snxt_reg == S_TX) begin
              ssh_reg <= txd_reg;
              s_sda_reg <= !txd_reg[7];
            end else begin
              s_sda_reg <= 1'b0;
            end
          end
        end
      end
    end

    // Open-drain outputs: the driven level is always low.
    assign scl_o[c] = 1'b0;
    assign sda_o[c] = 1'b0;
    assign scl_oe[c] = scl_drv_reg;
    assign sda_oe[c] = sda_oe_reg;
    assign irq[c] = irq_reg;
    assign wake_req[c] = wake_reg;
    assign stdby_req[c] = stdby_reg;
  end

endmodule

`default_nettype wire

// ==== hi2c_peer.sv ====
/* Far side of one two-wire bus: pull-ups, a bench-driven master and a slave that
   acks the first byte and records it. Assumes one core and the bench share the bus. */
`timescale 1ns/1ns
`default_nettype none
module hi2c_peer (
  // Pull-downs from the core and the bench.
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic m_scl,
  input wire logic m_sda,
  input wire logic ack_en,
  // Resolved lines and the byte seen.
  output logic scl,
  output logic sda,
  output logic [7:0] rx
);
  int n = 0;
  logic ack = 1'b0;
  // A released line rises through its pull-up, never showing the last value.
  assign scl = !(scl_oe || m_scl);
  assign sda = !(sda_oe || m_sda || ack);
  // Data falling with the clock high opens a frame.
  always @(negedge sda) if (scl) n = -1;
  // Bits are taken on the rising clock, first bit first.
  always @(posedge scl) if (n >= 0 && n < 8) rx = {rx[6:0], sda};
  // The ninth clock carries the acknowledge.
  always @(negedge scl) begin
    n = n + 1;
    ack = ack_en && n == 8;
  end
endmodule
`default_nettype wire

// ==== hi2c_pkg.sv ====
/*
  Shared constants for the two-wire serial core pair: register offsets,
  field positions, reset values, bus timing and state encodings.
  Assumes a 250 MHz APB clock and byte-wide registers in 32-bit words.
*/
`default_nettype none

package hi2c_pkg;

  // ------------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SCL_MAX_HZ = 400_000;
  // Shortest quarter bit period, rounded up so the line never beats 400 kHz.
  localparam int unsigned QTR_MIN = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam logic [15:0] QTR_MIN_W = 16'(QTR_MIN);

  // ------------------------------------------------------------------
  // Register map: core n sits at byte address n * 64, picked by address bit CORE_SEL_BIT.
  // ------------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam int NCORE = 2;
  localparam int CORE_SEL_BIT = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CMD = 6'h04;
  localparam logic [5:0] OFS_DIVLO = 6'h08;
  localparam logic [5:0] OFS_DIVHI = 6'h0C;
  localparam logic [5:0] OFS_TXD = 6'h10;
  localparam logic [5:0] OFS_RXD = 6'h14;
  localparam logic [5:0] OFS_SADLO = 6'h18;
  localparam logic [5:0] OFS_SADHI = 6'h1C;
  localparam logic [5:0] OFS_STAT = 6'h20;
  localparam logic [5:0] OFS_ISTAT = 6'h24;
  localparam logic [5:0] OFS_IMASK = 6'h28;

  // ------------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_MST = 1;
  localparam int CTRL_TEN = 2;
  localparam int CTRL_GC = 3;
  localparam int CTRL_WAKE = 4;
  localparam int CMD_STA = 0;
  localparam int CMD_STO = 1;
  localparam int CMD_RD = 2;
  localparam int CMD_WR = 3;
  localparam int CMD_NAK = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_TIP = 1;
  localparam int STAT_RXNAK = 2;
  localparam int STAT_ARBL = 3;
  localparam int STAT_ADDR = 4;
  localparam int STAT_SRW = 5;
  localparam int STAT_GC = 6;
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_ARB = 1;
  localparam int IRQ_ADR = 2;
  localparam int IRQ_STOP = 3;

  // ------------------------------------------------------------------
  // Reset values and fixed codes.
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [9:0] SAD_RST = 10'h000;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_START = 2'b01,
    M_BYTE = 2'b10,
    M_STOP = 2'b11
  } hi2c_mst_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADR1 = 3'b001,
    S_ADR2 = 3'b010,
    S_RX = 3'b011,
    S_TX = 3'b100,
    S_HOLD = 3'b101
  } hi2c_slv_e;

endpackage

`default_nettype wire

// ==== hi2c_sva.sv ====
/* Port checker for the core pair: APB timing, open-drain lines, gated power requests.
   Bound to every wrapper instance by the statement at the foot of this file. */
`timescale 1ns/1ns
`default_nettype none
module hi2c_sva
  import hi2c_pkg::*;
(
  // Clock, reset and APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line drivers and power requests.
  input wire logic [NCORE-1:0] scl_o,
  input wire logic [NCORE-1:0] scl_oe,
  input wire logic [NCORE-1:0] sda_o,
  input wire logic [NCORE-1:0] wake_req,
  input wire logic [NCORE-1:0] stdby_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] mst_reg;
  logic [1:0] wake_reg;
  logic hit;
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  // Mode and wake shadows follow a CTRL write at its commit edge.
  assign hit = psel && penable && pready && pwrite && !pslverr && paddr[5:0] == OFS_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_reg <= 2'b00;
      wake_reg <= 2'b00;
    end else if (hit) begin
      mst_reg[paddr[CORE_SEL_BIT]] <= pwdata[CTRL_MST];
      wake_reg[paddr[CORE_SEL_BIT]] <= pwdata[CTRL_WAKE];
    end
  end
  a_od_only: assert property (scl_o == 2'b00 && sda_o == 2'b00) else $error("line driven high");
  a_ready_wait: assert property (s_wait |=> pready) else $error("no answer after one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_only: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_far: assert property (psel && penable && pready && paddr[11:7] != 0 |-> pslverr)
    else $error("no error for unmapped address");
  a_byte_wide: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  a_slave_clk: assert property ((~mst_reg & ~$past(mst_reg) & scl_oe) == 2'b00)
    else $error("clock pulled in slave mode");
  a_wake_gate: assert property ((~wake_reg & ~$past(wake_reg) & (wake_req | stdby_req)) == 2'b00)
    else $error("power request without wake");
endmodule
bind hi2c_embedded_function_wrapper hi2c_sva hi2c_sva_i (.*);
`default_nettype wire

// ==== hi2c_sync.sv ====
/*
  Two-flop synchroniser for one line arriving from outside the pclk domain.
  Assumes the caller reads only q; the first stage is private.
*/
`timescale 1ns/1ns
`default_nettype none

module hi2c_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Line in and synchronised level out.
  input wire logic d_in,
  output logic q
);

  logic meta_reg;

  // ----------------------------------------------------------------
  // Two stages; an idle two-wire line rests high, hence the reset value.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d_in;
      q <= meta_reg;
    end
  end

endmodule

`default_nettype wire
